//--- hdl/ebw_defs.svh
`ifndef EBW_DEFS_SVH
`define EBW_DEFS_SVH
// register indices on the plain register port
`define EBW_ADDR_W          4
`define EBW_REG_DMA_WAIT    4'h0
`define EBW_REG_WAIT_PIN    4'h1
`define EBW_REG_DRAM_AREA   4'h2
`define EBW_REG_BUS_CTRL    4'h3
`define EBW_REG_STATUS      4'h4
// reset values
`define EBW_DMA_WAIT_RST    16'hFFFF
`define EBW_WAIT_PIN_RST    16'hF800
`define EBW_DRAM_AREA_RST   16'h0000
`define EBW_BUS_CTRL_RST    16'h0000
// field positions
`define EBW_WPU_BIT         15
`define EBW_A02LW_HI        14
`define EBW_A02LW_LO        13
`define EBW_A6LW_HI         12
`define EBW_A6LW_LO         11
`define EBW_WAIT_PIN_MASK   16'hF800
`define EBW_STROBE_BIT      15
`define EBW_ROW_STROBE_HOLD_LOW_BIT        14
`define EBW_TPC_BIT         13
`define EBW_BE_BIT          12
`define EBW_DRAM_AREA_MASK  16'hFF00
`define EBW_DRAM_SPACE_ON_BIT       0
// state counts
`define EBW_MUX_IO_STATES   3'h4
`define EBW_LONG_PITCH      3'h2
`endif

//--- hdl/ebw_pkg.sv
package ebw_pkg;
  // kind of space that a cycle targets
  typedef enum logic [1:0] {
    EBW_SPACE_EXT,
    EBW_SPACE_DRAM,
    EBW_SPACE_MUXIO
  } ebw_space_t;
  // cycle sequencer states
  typedef enum logic [2:0] {
    EBW_IDLE,
    EBW_ROW,
    EBW_DATA,
    EBW_WAITX,
    EBW_PRECH
  } ebw_state_t;
endpackage

//--- hdl/ebw_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// decoded settings from the register file to the sequencer
interface ebw_cfg_if;
  logic [7:0] dma_write_wait_sample;
  logic [7:0] dma_read_wait_sample;
  logic [1:0] area02_long_wait;
  logic [1:0] area6_long_wait;
  logic       strobe_style_select;
  logic       row_strobe_hold_low;
  logic       precharge_length;
  logic       page_burst_on;
  logic       dram_space_on;
  logic       wait_input_pullup;
  modport regs (output dma_write_wait_sample, dma_read_wait_sample, area02_long_wait, area6_long_wait,
                output strobe_style_select, row_strobe_hold_low, precharge_length, page_burst_on,
                output dram_space_on, wait_input_pullup);
  modport seq (input dma_write_wait_sample, dma_read_wait_sample, area02_long_wait, area6_long_wait,
               input strobe_style_select, row_strobe_hold_low, precharge_length, page_burst_on,
               input dram_space_on, wait_input_pullup);
endinterface
`default_nettype wire

//--- hdl/ebw_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebw_defs.svh"
// register file; power-on reset only, manual reset and standby do not touch it
module ebw_regs
  import ebw_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic [`EBW_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            status_in,
  output logic      [15:0]            reg_rdata,
  ebw_cfg_if.regs                     cfg
);
  logic [15:0] dma_wait_ctrl_ff;           // read and write wait selects
  logic [15:0] wait_pin_long_wait_ctrl_ff; // pull-up and long waits
  logic [15:0] dram_area_ctrl_ff;          // dram options
  logic [15:0] bus_control_reg_ff;         // dram enable bit only
  logic [15:0] nxt_rdata;

  // register writes; reserved bits are held at zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dma_wait_ctrl_ff           <= `EBW_DMA_WAIT_RST;
      wait_pin_long_wait_ctrl_ff <= `EBW_WAIT_PIN_RST;  // R10
      dram_area_ctrl_ff          <= `EBW_DRAM_AREA_RST; // R12
      bus_control_reg_ff         <= `EBW_BUS_CTRL_RST;
    end
    else if (ce && reg_wr)
    begin
      unique case (reg_addr)
        `EBW_REG_DMA_WAIT:  dma_wait_ctrl_ff <= reg_wdata; // R1
        `EBW_REG_WAIT_PIN:  wait_pin_long_wait_ctrl_ff <= reg_wdata & `EBW_WAIT_PIN_MASK; // R11
        `EBW_REG_DRAM_AREA: dram_area_ctrl_ff <= reg_wdata & `EBW_DRAM_AREA_MASK;
        `EBW_REG_BUS_CTRL:  bus_control_reg_ff <= {15'h0000, reg_wdata[`EBW_DRAM_SPACE_ON_BIT]};
        default:            ; // unmapped writes dropped
      endcase
    end
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    unique case (reg_addr)
      `EBW_REG_DMA_WAIT:  nxt_rdata = dma_wait_ctrl_ff;
      `EBW_REG_WAIT_PIN:  nxt_rdata = wait_pin_long_wait_ctrl_ff; // R11
      `EBW_REG_DRAM_AREA: nxt_rdata = dram_area_ctrl_ff;
      `EBW_REG_BUS_CTRL:  nxt_rdata = bus_control_reg_ff;
      `EBW_REG_STATUS:    nxt_rdata = status_in;
      default:            nxt_rdata = 16'h0000;
    endcase
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (ce && reg_rd)
      reg_rdata <= nxt_rdata;
  end

  // field decode
  assign cfg.dma_write_wait_sample = dma_wait_ctrl_ff[7:0];
  assign cfg.dma_read_wait_sample  = dma_wait_ctrl_ff[15:8];
  assign cfg.wait_input_pullup     = wait_pin_long_wait_ctrl_ff[`EBW_WPU_BIT];
  assign cfg.area02_long_wait      = wait_pin_long_wait_ctrl_ff[`EBW_A02LW_HI:`EBW_A02LW_LO];
  assign cfg.area6_long_wait       = wait_pin_long_wait_ctrl_ff[`EBW_A6LW_HI:`EBW_A6LW_LO];
  assign cfg.strobe_style_select   = dram_area_ctrl_ff[`EBW_STROBE_BIT];
  assign cfg.row_strobe_hold_low   = dram_area_ctrl_ff[`EBW_ROW_STROBE_HOLD_LOW_BIT];
  assign cfg.precharge_length      = dram_area_ctrl_ff[`EBW_TPC_BIT];
  assign cfg.page_burst_on         = dram_area_ctrl_ff[`EBW_BE_BIT];
  assign cfg.dram_space_on         = bus_control_reg_ff[`EBW_DRAM_SPACE_ON_BIT];
endmodule // ebw_regs
`default_nettype wire

//--- hdl/ebw_top.sv
// Behaviour
// R1 - eight per-area dma write wait bits
// R2 - bit 0 ignores wait, 1 samples
// R3 - areas 1,3-5,7: 1 or 2+wait states
// R4 - areas 0,2,6: 1 plus long wait
// R5 - dram column cycle short or long pitch
// R6 - muxed io: 4 states plus wait always
// R7 - pull-up bit drives wait pull-up, resets 1
// R8 - area 0/2 long wait 1-4 states
// R9 - area 6 long wait 1-4 states
// R10 - wait register set to F800 by power-on only
// R11 - reserved bits read zero, write zero
// R12 - dram options valid only with dram enable
// R13 - 16-bit: dual column or dual write strobes
// R14 - 8-bit: lower strobes only
// R15 - row strobe held low or released between
// R16 - precharge one or two states
// R17 - no burst: full access with row
// R18 - burst row hit: column phase only
// R19 - area 1 is dram only when enabled
// R20 - read wait bits follow same counts
// R21 - selection applies to single-mode dma only
`timescale 1ns/1ps
`default_nettype none
`include "ebw_defs.svh"
module ebw_top
  import ebw_pkg::*;
#(
  parameter int ROW_W = 20 // row address bits compared for page hits
)
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic [`EBW_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  input  wire logic                   cyc_start,
  input  wire logic [2:0]             cyc_area,
  input  wire logic                   cyc_write,
  input  wire logic                   cyc_dma_single,
  input  wire logic                   cyc_muxio,
  input  wire logic                   cyc_wide,
  input  wire logic                   cyc_odd,
  input  wire logic [ROW_W-1:0]       cyc_row,
  input  wire logic                   cyc_own_sample,
  input  wire logic [2:0]             cyc_own_states,
  input  wire logic                   wait_in_n,
  output logic                        cyc_busy,
  output logic                        cyc_done,
  output logic                        wait_input_pullup,
  output logic                        row_strobe_n,
  output logic                        col_strobe_upper_n,
  output logic                        col_strobe_lower_n,
  output logic                        write_strobe_upper_n,
  output logic                        write_strobe_lower_n,
  output logic                        row_addr_phase
);
  ebw_cfg_if cfg ();

  ebw_state_t  state_ff;            // sequencer state
  ebw_space_t  space_ff;            // space of current cycle
  logic [2:0]  cnt_ff;              // base states left
  logic        sample_ff;           // wait input honoured this cycle
  logic        write_ff;            // current cycle is a write
  logic        wide_ff;             // 16-bit access
  logic        odd_ff;              // upper byte lane of 16-bit
  logic        prech_ff;            // second precharge state pending
  logic        row_open_ff;         // row strobe left low
  logic        row_valid_ff;        // stored row is meaningful
  logic [ROW_W-1:0] last_row_ff;    // row of previous dram access
  logic [2:0]  nxt_cnt;
  logic        nxt_sample;
  ebw_space_t  nxt_space;
  logic [2:0]  long_wait;
  logic        sel_bit;
  logic        is_dram;
  logic        page_hit;
  logic [15:0] status_word;

  // register file
  ebw_regs u_regs (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .status_in (status_word),
    .reg_rdata (reg_rdata),
    .cfg       (cfg)
  );

  assign wait_input_pullup = cfg.wait_input_pullup; // R7
  assign status_word = {8'h00, 2'b00, row_open_ff, row_valid_ff, 1'b0, 3'(state_ff)};

  // area 1 becomes dram only while enabled
  assign is_dram = cfg.dram_space_on && (cyc_area == 3'h1); // R19 R12

  // long wait per area, encoding n gives n+1 states
  always_comb
  begin
    long_wait = 3'h0;
    if (cyc_area == 3'h0 || cyc_area == 3'h2)
      long_wait = {1'b0, cfg.area02_long_wait} + 3'h1; // R8
    else if (cyc_area == 3'h6)
      long_wait = {1'b0, cfg.area6_long_wait} + 3'h1;  // R9
  end

  // wait select bit: write bits for writes, read bits for reads
  assign sel_bit = cyc_write ? cfg.dma_write_wait_sample[cyc_area] // R1
                             : cfg.dma_read_wait_sample[cyc_area];  // R20

  // page hit only with burst on and matching stored row
  assign page_hit = cfg.page_burst_on && row_valid_ff && (last_row_ff == cyc_row); // R18 R17

  // cycle plan: base state count and wait sampling
  always_comb
  begin
    nxt_space  = EBW_SPACE_EXT;
    nxt_cnt    = 3'h1;
    nxt_sample = 1'b0;
    if (!cyc_dma_single)
    begin
      // other cycles keep their own settings
      nxt_cnt    = (cyc_own_states == 3'h0) ? 3'h1 : cyc_own_states; // R21
      nxt_sample = cyc_own_sample;
      if (is_dram)
        nxt_space = EBW_SPACE_DRAM;
      else if (cyc_muxio)
        nxt_space = EBW_SPACE_MUXIO;
    end
    else if (cyc_muxio)
    begin
      nxt_space  = EBW_SPACE_MUXIO;
      nxt_cnt    = `EBW_MUX_IO_STATES; // R6
      nxt_sample = 1'b1;
    end
    else if (is_dram)
    begin
      nxt_space  = EBW_SPACE_DRAM;
      nxt_cnt    = sel_bit ? `EBW_LONG_PITCH : 3'h1; // R5
      nxt_sample = sel_bit;
    end
    else if (long_wait != 3'h0)
    begin
      // areas 0, 2, 6: one state plus long wait
      nxt_cnt    = 3'(long_wait + 3'h1); // R4
      nxt_sample = sel_bit;              // R2
    end
    else
    begin
      nxt_cnt    = sel_bit ? `EBW_LONG_PITCH : 3'h1; // R3
      nxt_sample = sel_bit;                          // R2
    end
  end

  // sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff  <= EBW_IDLE;
      space_ff  <= EBW_SPACE_EXT;
      cnt_ff    <= 3'h0;
      sample_ff <= 1'b0;
      write_ff  <= 1'b0;
      wide_ff   <= 1'b0;
      odd_ff    <= 1'b0;
      prech_ff  <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_ff)
        EBW_IDLE:
        begin
          if (cyc_start)
          begin
            space_ff  <= nxt_space;
            cnt_ff    <= nxt_cnt;
            sample_ff <= nxt_sample;
            write_ff  <= cyc_write;
            wide_ff   <= cyc_wide;
            odd_ff    <= cyc_odd;
            // dram miss needs a row phase; hit goes to columns
            if (nxt_space == EBW_SPACE_DRAM && !page_hit)
              state_ff <= EBW_ROW;  // R17
            else
              state_ff <= EBW_DATA; // R18
          end
        end
        EBW_ROW:
          state_ff <= EBW_DATA;
        EBW_DATA:
        begin
          // last base state: wait input may stretch it
          if (cnt_ff <= 3'h1)
          begin
            if (sample_ff && !wait_in_n)
              state_ff <= EBW_WAITX; // R2
            else if (space_ff == EBW_SPACE_DRAM && !cfg.row_strobe_hold_low)
            begin
              state_ff <= EBW_PRECH; // R16
              prech_ff <= cfg.precharge_length;
            end
            else
              state_ff <= EBW_IDLE;
          end
          else
            cnt_ff <= cnt_ff - 3'h1;
        end
        EBW_WAITX:
        begin
          if (wait_in_n)
          begin
            if (space_ff == EBW_SPACE_DRAM && !cfg.row_strobe_hold_low)
            begin
              state_ff <= EBW_PRECH;
              prech_ff <= cfg.precharge_length;
            end
            else
              state_ff <= EBW_IDLE;
          end
        end
        EBW_PRECH:
        begin
          // one or two precharge states
          if (prech_ff)
            prech_ff <= 1'b0;  // R16
          else
            state_ff <= EBW_IDLE;
        end
      endcase
    end
  end

  // row tracking for page mode and held row strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      row_open_ff  <= 1'b0;
      row_valid_ff <= 1'b0;
      last_row_ff  <= '0;
    end
    else if (ce)
    begin
      if (!cfg.dram_space_on)
      begin
        row_open_ff  <= 1'b0;
        row_valid_ff <= 1'b0;
      end
      else if (state_ff == EBW_IDLE && cyc_start && nxt_space == EBW_SPACE_DRAM && !page_hit)
      begin
        last_row_ff  <= cyc_row;
        row_valid_ff <= 1'b1;
        row_open_ff  <= 1'b1;
      end
      else if (state_ff == EBW_PRECH)
      begin
        row_open_ff  <= 1'b0; // R15
        row_valid_ff <= 1'b0;
      end
    end
  end

  // handshake outputs
  assign cyc_busy       = (state_ff != EBW_IDLE);
  assign cyc_done       = ce && (((state_ff == EBW_DATA) && (cnt_ff <= 3'h1) && !(sample_ff && !wait_in_n))
                          || ((state_ff == EBW_WAITX) && wait_in_n));
  assign row_addr_phase = (state_ff == EBW_ROW);

  // dram strobes, active low
  always_comb
  begin
    logic col_act;
    col_act              = 1'b0;
    col_strobe_upper_n   = 1'b1;
    col_strobe_lower_n   = 1'b1;
    write_strobe_upper_n = 1'b1;
    write_strobe_lower_n = 1'b1;
    col_act = (space_ff == EBW_SPACE_DRAM) && (state_ff == EBW_DATA || state_ff == EBW_WAITX);
    if (col_act)
    begin
      if (!wide_ff)
      begin
        col_strobe_lower_n   = 1'b0;       // R14
        write_strobe_lower_n = !write_ff;
      end
      else if (!cfg.strobe_style_select)
      begin
        // dual column strobe with one write strobe
        col_strobe_upper_n   = 1'b0;       // R13
        col_strobe_lower_n   = 1'b0;
        write_strobe_lower_n = !write_ff;
      end
      else
      begin
        // one column strobe with two write strobes
        col_strobe_lower_n   = 1'b0;       // R13
        write_strobe_upper_n = !write_ff;
        write_strobe_lower_n = !write_ff;
      end
    end
  end

  // row strobe low while row open and not precharging
  assign row_strobe_n = !(row_open_ff && state_ff != EBW_PRECH); // R15
endmodule // ebw_top
`default_nettype wire

//--- sim/ebw_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// timing and strobe relations seen at the top ports
module ebw_top_sva
  import ebw_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        cyc_start,
  input wire logic [2:0]  cyc_area,
  input wire logic        cyc_write,
  input wire logic        cyc_dma_single,
  input wire logic        cyc_muxio,
  input wire logic        cyc_wide,
  input wire logic        cyc_busy,
  input wire logic        cyc_done,
  input wire logic        wait_input_pullup,
  input wire logic        row_strobe_n,
  input wire logic        col_strobe_upper_n,
  input wire logic        write_strobe_upper_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] wait_sh_ff; // shadow of dma wait control
  logic        style_ff;   // shadow of strobe style
  logic        dram_ff;    // shadow of dram enable
  logic        wide_ff;    // width of the running cycle
  wire         take = cyc_start && ce && !cyc_busy;
  wire         sel = wait_sh_ff[{!cyc_write, cyc_area}];
  wire         ext_short = take && cyc_dma_single && !cyc_muxio && !sel &&
                           (cyc_area inside {3'h3, 3'h4, 3'h5, 3'h7} || (cyc_area == 3'h1 && !dram_ff));
  // register shadows follow accepted writes
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      wait_sh_ff <= 16'hFFFF;
      style_ff   <= 1'b0;
      dram_ff    <= 1'b0;
    end
    else if (reg_wr && ce)
    begin
      if (reg_addr == 4'h0) wait_sh_ff <= reg_wdata;
      if (reg_addr == 4'h2) style_ff <= reg_wdata[15];
      if (reg_addr == 4'h3) dram_ff <= reg_wdata[0];
    end
  // width latched when a cycle is taken
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      wide_ff <= 1'b0;
    else if (take)
      wide_ff <= cyc_wide;
  sequence s_mux_take;
    take && cyc_muxio && cyc_dma_single;
  endsequence
  sequence s_quiet3;
    !cyc_done [*3];
  endsequence
  chk_pullup_follow: assert property (reg_wr && ce && reg_addr == 4'h1 |=> wait_input_pullup == $past(reg_wdata[15]))
    else $error("pull-up does not follow its bit");
  chk_wait_rsvd_zero: assert property (reg_rd && ce && reg_addr == 4'h1 |=> reg_rdata[10:0] == 11'h000)
    else $error("wait register low bits not zero");
  chk_dram_rsvd_zero: assert property (reg_rd && ce && reg_addr == 4'h2 |=> reg_rdata[7:0] == 8'h00)
    else $error("dram register low byte not zero");
  chk_ext_short_one: assert property (ext_short |=> cyc_done)
    else $error("short external cycle not one state");
  chk_muxio_four: assert property (s_mux_take |=> s_quiet3)
    else $error("muxed io cycle ended early");
  chk_lane_narrow: assert property (dram_ff && !wide_ff |-> col_strobe_upper_n && write_strobe_upper_n)
    else $error("upper strobe on narrow access");
  chk_dual_col: assert property (dram_ff && wide_ff && !style_ff |-> write_strobe_upper_n)
    else $error("upper write strobe in dual column mode");
  chk_dual_write: assert property (dram_ff && wide_ff && style_ff |-> col_strobe_upper_n)
    else $error("upper column strobe in dual write mode");
  chk_ext_no_row: assert property (!dram_ff && !$past(dram_ff) |-> row_strobe_n)
    else $error("row strobe outside dram space");
endmodule // ebw_top_sva
bind ebw_top ebw_top_sva u_sva (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_start(cyc_start), .cyc_area(cyc_area),
  .cyc_write(cyc_write), .cyc_dma_single(cyc_dma_single), .cyc_muxio(cyc_muxio), .cyc_wide(cyc_wide),
  .cyc_busy(cyc_busy), .cyc_done(cyc_done), .wait_input_pullup(wait_input_pullup), .row_strobe_n(row_strobe_n),
  .col_strobe_upper_n(col_strobe_upper_n), .write_strobe_upper_n(write_strobe_upper_n));
`default_nettype wire

//--- sim/ebw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// external memory holding the wait line low for a set count
module ebw_mem_model
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       cyc_start,
  input  wire logic       cyc_busy,
  input  wire logic       wait_input_pullup,
  input  wire logic [3:0] wait_len,
  output logic            wait_in_n
);
  logic [3:0] left_ff; // wait states still to hold
  logic       pat_ff;  // changing level while released
  // count loaded when a cycle is taken
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      left_ff <= 4'h0;
      pat_ff  <= 1'b0;
    end
    else
    begin
      pat_ff <= !pat_ff;
      if (cyc_start && !cyc_busy)
        left_ff <= wait_len;
      else if (left_ff != 4'h0)
        left_ff <= left_ff - 4'h1;
    end
  // low while waiting, high in a cycle, else pull-up or noise
  assign wait_in_n = (left_ff != 4'h0) ? 1'b0 : (cyc_busy || wait_input_pullup) ? 1'b1 : pat_ff;
endmodule // ebw_mem_model
`default_nettype wire

//--- sim/ebw_top_test.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the wait and dram control block
module ebw_top_test;
  logic        clk, rstn, ce, reg_wr, reg_rd, cyc_start, cyc_write, cyc_dma_single, cyc_muxio, cyc_wide;
  logic [3:0]  reg_addr, wait_len;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  cyc_area, cyc_own_states;
  logic [19:0] cyc_row;
  logic        cyc_own_sample, wait_in_n, cyc_busy, cyc_done, wait_input_pullup, row_strobe_n, row_addr_phase;
  logic        col_strobe_upper_n, col_strobe_lower_n, write_strobe_upper_n, write_strobe_lower_n;
  logic [15:0] m_wait, m_pin, m_dram; // model register copies
  logic        m_en, rv;              // model dram enable, row valid
  int          last_row, err_total, n_tests, seed_v, ar, dm;
  ebw_top #(.ROW_W(20)) u_dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_start(cyc_start), .cyc_area(cyc_area),
    .cyc_write(cyc_write), .cyc_dma_single(cyc_dma_single), .cyc_muxio(cyc_muxio), .cyc_wide(cyc_wide),
    .cyc_odd(1'b0), .cyc_row(cyc_row), .cyc_own_sample(cyc_own_sample), .cyc_own_states(cyc_own_states),
    .wait_in_n(wait_in_n), .cyc_busy(cyc_busy), .cyc_done(cyc_done), .wait_input_pullup(wait_input_pullup),
    .row_strobe_n(row_strobe_n), .col_strobe_upper_n(col_strobe_upper_n), .col_strobe_lower_n(col_strobe_lower_n),
    .write_strobe_upper_n(write_strobe_upper_n), .write_strobe_lower_n(write_strobe_lower_n),
    .row_addr_phase(row_addr_phase));
  ebw_mem_model u_mem (.clk(clk), .rstn(rstn), .cyc_start(cyc_start), .cyc_busy(cyc_busy),
    .wait_input_pullup(wait_input_pullup), .wait_len(wait_len), .wait_in_n(wait_in_n));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // register write, model keeps only documented bits
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      4'h0: m_wait = d;
      4'h1: m_pin = d & 16'hF800;
      4'h2: m_dram = d & 16'hFF00;
      4'h3: {m_en, rv} = {d[0], rv & d[0]};
      default: ;
    endcase
  endtask
  // register read, data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  // power-on reset, then registers 0-3 and an unmapped index against reset values, status not read
  task automatic rst_chk;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    m_wait = 16'hFFFF;
    m_pin = 16'hF800;
    m_dram = 16'h0000;
    m_en = 1'b0;
    rv = 1'b0;
    rd(4'h0, m_wait);
    rd(4'h1, m_pin);
    rd(4'h2, m_dram);
    rd(4'h3, 16'h0000);
    rd(4'hF, 16'h0000);
    chk("wait_input_pullup", 1'b1, wait_input_pullup);
  endtask
  // one bus cycle timed against the model
  task automatic cyc(input int a, input bit w_, input bit dma, input bit mux, input bit wd, input int row, input int w);
    int e, n, pre, os, s;
    bit dr, hit, cu, wu, rp, cl, wl;
    os = $urandom_range(7, 0);
    s = dma ? m_wait[w_ ? a : a + 8] : $urandom_range(1, 0);
    dr = a == 1 && m_en && !mux;
    hit = dr && m_dram[12] && rv && row == last_row;
    if (mux) e = 4 + w;
    else if (dr) e = (s ? 2 + w : 1) + !hit;
    else if (!dma) e = (os == 0 ? 1 : os) + (s ? w : 0);
    else if (a == 0 || a == 2) e = 2 + m_pin[14:13] + (s ? w : 0);
    else if (a == 6) e = 2 + m_pin[12:11] + (s ? w : 0);
    else e = s ? 2 + w : 1;
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_area <= 3'(a);
    cyc_write <= w_;
    cyc_dma_single <= dma;
    cyc_muxio <= mux;
    cyc_wide <= wd;
    cyc_row <= 20'(row);
    cyc_own_sample <= 1'(s);
    cyc_own_states <= 3'(os);
    // wait held low from the take so that w states land on the sampled last state
    wait_len <= (w == 0) ? 4'h0 : 4'(e - 1 + ((s || mux) ? 0 : w));
    @(posedge clk);
    cyc_start <= 1'b0;
    {n, pre, cu, wu, rp, cl, wl} = {32'h0, 32'h0, 5'b11011};
    do
    begin
      @(negedge clk);
      n++;
      cu &= col_strobe_upper_n;
      wu &= write_strobe_upper_n;
      rp |= row_addr_phase;
      cl &= col_strobe_lower_n;
      wl &= write_strobe_lower_n;
    end
    while (cyc_done !== 1'b1 && n < 40);
    // count only the busy states after the done state
    @(negedge clk);
    while (cyc_busy === 1'b1 && pre < 8)
    begin
      pre++;
      @(negedge clk);
    end
    chk("cycle_states", 16'(e), 16'(n));
    if (dr)
    begin
      chk("col_strobe_upper_n", !(wd && !m_dram[15]), cu);
      chk("write_strobe_upper_n", !(wd && m_dram[15] && w_), wu);
      chk("col_strobe_lower_n", 16'h0000, 16'(cl));
      chk("write_strobe_lower_n", 16'(!w_), 16'(wl));
      chk("row_addr_phase", !hit, rp);
      chk("precharge", m_dram[14] ? 16'h0 : 16'(m_dram[13] + 1), 16'(pre));
      chk("row_strobe_n", !m_dram[14], row_strobe_n);
      // the row stays valid only while the row strobe is held low
      rv = m_dram[14];
      last_row = row;
    end
  endtask
  // watchdog against a hang
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
  // main sequence
  initial
  begin
    {rstn, ce, reg_wr, reg_rd, cyc_start, cyc_write, cyc_dma_single, cyc_muxio, cyc_wide} = 9'b010000000;
    {reg_addr, wait_len, reg_wdata, cyc_area, cyc_own_states, cyc_row, cyc_own_sample} = '0;
    {err_total, n_tests, last_row} = '0;
    seed_v = $urandom(32'h7edb);
    rst_chk();
    wr(4'h1, 16'hFFFF);
    rd(4'h1, m_pin);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, m_dram);
    // random traffic over external and muxed space
    repeat (40)
    begin
      wr(4'h0, 16'($urandom));
      wr(4'h1, 16'($urandom) & 16'hF800);
      @(negedge clk);
      chk("wait_input_pullup", m_pin[15], wait_input_pullup);
      dm = $urandom_range(1, 0);
      ar = dm ? $urandom_range(7, 0) : 3 + $urandom_range(3, 0);
      if (!dm && ar == 6) ar = 7;
      cyc(ar, $urandom_range(1, 0), dm, dm && $urandom_range(3, 0) == 0, 1, $urandom, $urandom_range(3, 0));
    end
    // dram strobe styles, widths and precharge lengths
    wr(4'h3, 16'h0001);
    for (int k = 0; k < 8; k++)
    begin
      wr(4'h0, 16'($urandom));
      wr(4'h2, {k[0], 1'b0, k[1], 13'h0});
      cyc(1, 1, 1, 0, k[2], k, $urandom_range(2, 0));
    end
    // row held low with page bursts
    wr(4'h2, 16'h5000);
    cyc(1, 1, 1, 0, 1, 100, 0);
    cyc(1, 1, 1, 0, 1, 100, 1);
    cyc(1, 1, 1, 0, 1, 101, 0);
    wr(4'h2, 16'h0000);
    cyc(1, 1, 1, 0, 0, 101, 0);
    wr(4'h3, 16'h0000);
    cyc(1, 1, 1, 0, 1, 5, 1);
    rst_chk();
    final_report();
  end
endmodule // ebw_top_test
`default_nettype wire
